// *** design/sac_ctrl.sv ***
// Functional notes
// - Each conversion yields a 10-bit unsigned code by successive approximation.
// - A six-way selector routes one of four pins, the temperature or battery sensor.
// - One conversion lasts 20 sample clock cycles, 5 us at 4 MHz.
// - Eight divider settings from 1.00 down to 0.24 apply to external inputs only.
// - Modes are absolute, ratio, pseudo-differential and ratio pseudo-differential.
// - Absolute mode gives the input against the fixed 950 mV reference.
// - Ratio mode runs two conversions back to back and divides the first by the second.
// - Pseudo-differential mode runs two conversions and gives their difference.
// - Ratio pseudo-differential runs three and divides first minus second by the third.
// - Single mode gives one result per request; continuous repeats until stopped.
// - A readable busy bit is set during a sequence and clear when idle.
// - A maskable interrupt is raised when a conversion sequence completes.
//
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
`include "sac_params.svh"

module sac_ctrl (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic cmp_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic irq_o,
  output logic [2:0] mux_o,
  output logic [2:0] scale_o,
  output logic sample_o,
  output logic sclk_o,
  output logic [9:0] dac_o
);
  import sac_pkg::*;

  localparam int unsigned DIV = (`SAC_SYS_HZ + `SAC_SCLK_HZ - 1) / `SAC_SCLK_HZ;
  localparam logic [5:0] DIV_LAST = 6'(DIV - 1);
  localparam logic [5:0] DIV_HALF = 6'(DIV / 2);
  localparam logic [4:0] LAST_TICK = 5'(`SAC_CONV_TICKS - 1);
  localparam logic [4:0] SAMP_LAST = 5'(`SAC_CONV_TICKS - `SAC_CODE_W - 1);

  logic [5:0] div_cnt;
  logic tick;
  logic ap_valid;
  logic ap_write;
  logic [7:0] ap_addr;
  logic ap_take;
  logic wr_en;
  logic [15:0] cfg;
  logic start_req;
  logic irq_mask;
  logic irq_stat;
  logic busy;
  logic [15:0] result;
  sac_state_t st;
  logic [1:0] idx;
  logic [4:0] tcnt;
  logic [9:0] sar;
  logic [9:0] code [3];
  sac_mode_t mode;
  logic [1:0] last_idx;
  logic [2:0] cur_ch;
  logic [3:0] bp;
  logic [9:0] next_sar;
  logic [15:0] next_result;
  logic signed [10:0] diff;
  logic [9:0] mag;
  logic [15:0] q_ab;
  logic [15:0] q_dc;
  logic [14:0] q15;

  ////////////////////////////////////////////////////////////////////////////
  // Sample clock: rounded down so that 20 ticks never undercut 5 us
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt <= 6'h00;
      sclk_o <= 1'b0;
    end else if (ce_i) begin
      div_cnt <= (div_cnt == DIV_LAST) ? 6'h00 : div_cnt + 6'h01;
      sclk_o <= (div_cnt < DIV_HALF);
    end
  end

  assign tick = ce_i && (div_cnt == DIV_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase capture; slave never inserts wait states
  assign ap_take = hsel_i && htrans_i[1] && hready_i;
  assign wr_en = ap_valid && ap_write;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else if (ce_i) begin
      ap_valid <= ap_take;
      ap_write <= hwrite_i;
      ap_addr <= haddr_i[7:0];
    end
  end

  // Read data is picked up at the address phase so it stands in the data phase
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (ce_i && ap_take && !hwrite_i) begin
      case (haddr_i[7:0])
        `SAC_OFS_CTRL: hrdata_o <= {16'h0000, cfg};
        `SAC_OFS_STATUS: hrdata_o <= {31'h0000_0000, busy};
        `SAC_OFS_RESULT: hrdata_o <= {16'h0000, result};
        `SAC_OFS_IRQ_STAT: hrdata_o <= {31'h0000_0000, irq_stat};
        `SAC_OFS_IRQ_MASK: hrdata_o <= {31'h0000_0000, irq_mask};
        default: hrdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Control and mask writes; start is a self-clearing command bit
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg <= `SAC_CTRL_RST;
      irq_mask <= `SAC_MASK_RST;
    end else if (ce_i && wr_en) begin
      if (ap_addr == `SAC_OFS_CTRL) begin
        cfg <= {hwdata_i[15:1], 1'b0};
      end
      if (ap_addr == `SAC_OFS_IRQ_MASK) begin
        irq_mask <= hwdata_i[`SAC_IRQ_DONE];
      end
    end
  end

  assign start_req = wr_en && (ap_addr == `SAC_OFS_CTRL) && hwdata_i[`SAC_CTRL_START];

  ////////////////////////////////////////////////////////////////////////////
  // Sequence shape per mode
  assign mode = sac_mode_t'(cfg[`SAC_CTRL_MODE +: 2]);

  always_comb begin
    case (mode)
      SAC_MODE_ABS: last_idx = 2'd0;
      SAC_MODE_RATIO: last_idx = 2'd1;
      SAC_MODE_PDIFF: last_idx = 2'd1;
      SAC_MODE_RPDIFF: last_idx = 2'd2;
      default: last_idx = 2'd0;
    endcase
  end

  // Input selection: 0..3 pins, 4 temperature, 5 battery
  always_comb begin
    case (idx)
      2'd0: cur_ch = cfg[`SAC_CTRL_CHA +: 3];
      2'd1: cur_ch = cfg[`SAC_CTRL_CHB +: 3];
      default: cur_ch = cfg[`SAC_CTRL_CHC +: 3];
    endcase
  end

  // Divider only reaches pins, so sensors always see unity scale
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mux_o <= 3'h0;
      scale_o <= 3'h0;
    end else if (ce_i) begin
      mux_o <= cur_ch;
      scale_o <= (cur_ch < 3'(`SAC_EXT_INPUTS)) ? cfg[`SAC_CTRL_SCALE +: 3] : 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One SAR trial: drop the bit under test if the comparator says too high
  assign bp = 4'(LAST_TICK - tcnt);

  always_comb begin
    next_sar = sar;
    if (!cmp_i) begin
      next_sar[bp] = 1'b0;
    end
    if (bp != 4'h0) begin
      next_sar[bp - 4'h1] = 1'b1;
    end
  end

  // Sequencer: 10 sample ticks then 10 bit trials per conversion
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= S_IDLE;
      idx <= 2'd0;
      tcnt <= 5'h00;
      sar <= 10'h000;
      sample_o <= 1'b0;
      code[0] <= 10'h000;
      code[1] <= 10'h000;
      code[2] <= 10'h000;
    end else if (ce_i) begin
      case (st)
        S_IDLE: begin
          if (start_req) begin
            st <= S_CONV;
            idx <= 2'd0;
            tcnt <= 5'h00;
          end
        end
        S_CONV: begin
          if (tick) begin
            if (tcnt < SAMP_LAST) begin
              sample_o <= 1'b1;
              sar <= 10'h000;
              tcnt <= tcnt + 5'h01;
            end else if (tcnt == SAMP_LAST) begin
              sample_o <= 1'b0;
              sar <= 10'h200;
              tcnt <= tcnt + 5'h01;
            end else begin
              sar <= next_sar;
              if (tcnt == LAST_TICK) begin
                code[idx] <= next_sar;
                tcnt <= 5'h00;
                if (idx == last_idx) begin
                  st <= S_CALC;
                end else begin
                  idx <= idx + 2'd1;
                end
              end else begin
                tcnt <= tcnt + 5'h01;
              end
            end
          end
        end
        S_CALC: begin
          idx <= 2'd0;
          st <= cfg[`SAC_CTRL_CONT] ? S_CONV : S_IDLE;
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  assign dac_o = sar;

  ////////////////////////////////////////////////////////////////////////////
  // Result arithmetic: ratios are Q10 fixed point, saturated on overflow
  function automatic logic [15:0] sac_div(input logic [9:0] num, input logic [9:0] den);
    logic [19:0] q;
    q = 20'h00000;
    if (den == 10'h000) begin
      sac_div = 16'hFFFF;
    end else begin
      q = {num, 10'h000} / {10'h000, den};
      sac_div = (q[19:16] != 4'h0) ? 16'hFFFF : q[15:0];
    end
  endfunction

  assign diff = $signed({1'b0, code[0]}) - $signed({1'b0, code[1]});
  assign mag = diff[10] ? 10'(-diff) : diff[9:0];
  assign q_ab = sac_div(code[0], code[1]);
  assign q_dc = sac_div(mag, code[2]);
  assign q15 = q_dc[15] ? 15'h7FFF : q_dc[14:0];

  always_comb begin
    case (mode)
      SAC_MODE_ABS: next_result = {6'h00, code[0]};
      SAC_MODE_RATIO: next_result = q_ab;
      SAC_MODE_PDIFF: next_result = {{5{diff[10]}}, diff};
      SAC_MODE_RPDIFF: next_result = diff[10] ? 16'(-{1'b0, q15}) : {1'b0, q15};
      default: next_result = 16'h0000;
    endcase
  end

  // Result, busy and done flag all change on the calculation cycle
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result <= `SAC_RESULT_RST;
      busy <= 1'b0;
    end else if (ce_i) begin
      if (st == S_CALC) begin
        result <= next_result;
        busy <= 1'b0;
      end else begin
        busy <= (st == S_CONV) || start_req;
      end
    end
  end

  // Sticky done flag, cleared by reading it; a new completion wins over the read
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat <= 1'b0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      if (st == S_CALC) begin
        irq_stat <= 1'b1;
      end else if (ap_take && !hwrite_i && haddr_i[7:0] == `SAC_OFS_IRQ_STAT) begin
        irq_stat <= 1'b0;
      end
      irq_o <= irq_stat && irq_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [4:0] chk_ticks;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chk_ticks <= 5'h00;
    end else if (tick && st == S_CONV) begin
      chk_ticks <= (tcnt == LAST_TICK) ? 5'h00 : chk_ticks + 5'h01;
    end
  end

  default clocking dcb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  conv_length_a: assert property (tick && st == S_CONV && tcnt == LAST_TICK |-> chk_ticks == 5'd19) else $error("conversion not 20 ticks");
  code_width_a: assert property (st == S_CALC && mode == SAC_MODE_ABS && ce_i |=> result[15:10] == 6'h00) else $error("absolute result exceeds 10 bits");
  ratio_count_a: assert property (st == S_CALC && mode == SAC_MODE_RATIO |-> idx == 2'd1) else $error("ratio not two conversions");
  rpd_count_a: assert property (st == S_CALC && mode == SAC_MODE_RPDIFF |-> idx == 2'd2) else $error("ratio pdiff not three conversions");
  diff_result_a: assert property (st == S_CALC && mode == SAC_MODE_PDIFF && ce_i |=> result == $past(next_result) && $signed(result) == $signed($past(diff))) else $error("difference wrong");
  done_flag_a: assert property (st == S_CALC && ce_i |=> irq_stat && !busy) else $error("done flag or busy wrong after result");
  idle_busy_a: assert property (st == S_IDLE && !$past(start_req) |-> !busy) else $error("busy while idle");
  irq_level_a: assert property (ce_i && irq_stat && irq_mask |=> irq_o) else $error("interrupt not raised");
  cont_restart_a: assert property (st == S_CALC && ce_i && cfg[`SAC_CTRL_CONT] |=> st == S_CONV ##1 busy) else $error("continuous did not restart");
  single_stop_a: assert property (st == S_CALC && ce_i && !cfg[`SAC_CTRL_CONT] |=> st == S_IDLE) else $error("single mode did not stop");
  sensor_scale_a: assert property (ce_i && cur_ch >= 3'd4 |=> scale_o == 3'h0) else $error("sensor was scaled");

  single_abs_c: cover property (st == S_CALC && mode == SAC_MODE_ABS && !cfg[`SAC_CTRL_CONT]);
  ratio_done_c: cover property (st == S_CALC && mode == SAC_MODE_RATIO);
  rpd_done_c: cover property (st == S_CALC && mode == SAC_MODE_RPDIFF);
  cont_again_c: cover property (st == S_CALC && cfg[`SAC_CTRL_CONT] ##1 st == S_CONV);
endmodule

// *** design/sac_params.svh ***
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

// Register byte offsets
`define SAC_OFS_CTRL 8'h00
`define SAC_OFS_STATUS 8'h04
`define SAC_OFS_RESULT 8'h08
`define SAC_OFS_IRQ_STAT 8'h0C
`define SAC_OFS_IRQ_MASK 8'h10

// Control register field positions
`define SAC_CTRL_START 0
`define SAC_CTRL_CONT 1
`define SAC_CTRL_MODE 2
`define SAC_CTRL_CHA 4
`define SAC_CTRL_CHB 7
`define SAC_CTRL_CHC 10
`define SAC_CTRL_SCALE 13
`define SAC_CTRL_W 16

// Status and interrupt bit positions
`define SAC_STATUS_BUSY 0
`define SAC_IRQ_DONE 0

// Reset values
`define SAC_CTRL_RST 16'h0000
`define SAC_MASK_RST 1'h0
`define SAC_RESULT_RST 16'h0000

// Timing
`define SAC_SYS_HZ 125000000
`define SAC_SCLK_HZ 4000000
`define SAC_CONV_TICKS 20
`define SAC_CODE_W 10
`define SAC_EXT_INPUTS 4

`endif

// *** design/sac_pkg.sv ***
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_MODE_ABS,
    SAC_MODE_RATIO,
    SAC_MODE_PDIFF,
    SAC_MODE_RPDIFF
  } sac_mode_t;

  typedef enum logic [1:0] {
    S_IDLE,
    S_CONV,
    S_CALC
  } sac_state_t;
endpackage

// *** sim/sac_cmp_model.sv ***
`timescale 1ns/1ns
// Analogue side: six fixed sources and the comparator behind the selector
module sac_cmp_model (
  input wire logic [2:0] mux_i,
  input wire logic [9:0] dac_i,
  output logic cmp_o
);
  logic [9:0] level [0:5];
  ////////////////////////////////////////
  // Pins 0..3, then temperature and battery sensor levels as ideal codes
  initial begin
    level[0] = 10'h12C;
    level[1] = 10'h2BC;
    level[2] = 10'h000;
    level[3] = 10'h3FF;
    level[4] = 10'h200;
    level[5] = 10'h064;
  end
  // Bit kept while source is at or above the trial code; unused selects read low
  assign cmp_o = (mux_i <= 3'h5) ? (level[mux_i] >= dac_i) : 1'b0;
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ns
`include "sac_params.svh"
module tb;
  logic mclk_i, arst_n_i, hsel_i, hwrite_i, cmp_i, hready, hresp_o, irq_o;
  logic sample_o, sclk_o, ce;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rdv;
  logic [1:0] htrans_i;
  logic [2:0] mux_o, scale_o;
  logic [9:0] dac_o;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int k;
  sac_ctrl dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hready), .cmp_i(cmp_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hready), .hresp_o(hresp_o), .irq_o(irq_o), .mux_o(mux_o),
    .scale_o(scale_o), .sample_o(sample_o), .sclk_o(sclk_o), .dac_o(dac_o));
  sac_cmp_model pm (.mux_i(mux_o), .dac_i(dac_o), .cmp_o(cmp_i));
  ////////////////////////////////////////
  // Free-running clock and a cycle count for timing checks
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) cyc <= cyc + 1;
  task automatic complete_run();
    $display("comparisons %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk1(input string nm, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic hang();
    error_cnt++;
    $display("mismatch wait bound expected done seen timeout");
    complete_run();
  endtask
  // Sample hready at each edge; only the bound ends a stalled wait
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge mclk_i);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) hang();
      @(posedge mclk_i);
    end
  endtask
  // One single word transfer; read data is taken at the data phase edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= wr;
    wait_rdy();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    wait_rdy();
    rdv = hrdata_o;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 32'h0);
    chk32(nm, exp, rdv);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_o !== 1'b1) begin
      n++;
      if (n > 4000) hang();
      @(posedge mclk_i);
    end
  endtask
  // Result per mode: ratio saturates, differences are 16-bit two's complement
  function automatic logic [15:0] expv(input logic [1:0] md, input int a, b, c);
    int d, q;
    d = a - b;
    // A zero reference saturates, as a zero divisor does in ratio mode
    q = c == 0 ? 32767 : (d < 0 ? -d : d) * 1024 / c;
    q = q > 32767 ? 32767 : q;
    case (md)
      2'h0: return a[15:0];
      2'h1: return (b == 0 || a * 1024 / b > 65535) ? 16'hFFFF : 16'(a * 1024 / b);
      2'h2: return d[15:0];
      default: return d < 0 ? 16'(-q) : q[15:0];
    endcase
  endfunction
  ////////////////////////////////////////
  // Start one sequence and check selector, timing, result and completion flags
  task automatic conv(input logic [1:0] md, input logic [2:0] a, b, c, sc, input int n);
    logic [15:0] ctl;
    int t0;
    int e;
    ctl = {sc, c, b, a, md, 2'b01};
    // Select the input first and let it settle 7 time constants at the chosen divider setting
    bus(1'b1, `SAC_OFS_CTRL, {16'h0, ctl[15:1], 1'b0});
    repeat (140) @(posedge mclk_i);
    bus(1'b1, `SAC_OFS_CTRL, {16'h0, ctl});
    t0 = cyc;
    rd_chk(`SAC_OFS_CTRL, {16'h0, ctl[15:1], 1'b0}, "ctrl");
    rd_chk(`SAC_OFS_STATUS, 32'h1, "busy");
    for (k = 0; k < 64 && sample_o !== 1'b1; k++) @(posedge mclk_i);
    chk1("sample", 1'b1, sample_o);
    // Sample clock is half high over any 32 system cycles
    e = 0;
    repeat (32) begin
      @(posedge mclk_i);
      e += sclk_o;
    end
    chk32("sclk high", 32'd16, e);
    chk32("mux", {29'h0, a}, {29'h0, mux_o});
    chk32("scale", {29'h0, a < 3'h4 ? sc : 3'h0}, {29'h0, scale_o});
    wait_irq();
    chk1("duration", 1'b1, cyc - t0 >= (20 * n - 1) * 32 && cyc - t0 <= 20 * n * 32 + 40);
    // Trial code left on the converter is the last source's ideal code
    e = n == 1 ? a : (n == 2 ? b : c);
    chk32("dac", {22'h0, pm.level[e]}, {22'h0, dac_o});
    rd_chk(`SAC_OFS_RESULT, {16'h0, expv(md, pm.level[a], pm.level[b], pm.level[c])},
      "result");
    rd_chk(`SAC_OFS_IRQ_STAT, 32'h1, "done");
    rd_chk(`SAC_OFS_IRQ_STAT, 32'h0, "done clear");
    rd_chk(`SAC_OFS_STATUS, 32'h0, "idle");
    chk1("irq low", 1'b0, irq_o);
  endtask
  initial begin
    arst_n_i = 1'b0;
    ce = 1'b1;
    hsel_i = 1'b0;
    htrans_i = 2'h0;
    haddr_i = 32'h0;
    hwrite_i = 1'b0;
    hwdata_i = 32'h0;
    repeat (20) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    rd_chk(`SAC_OFS_CTRL, 32'h0, "ctrl rst");
    rd_chk(`SAC_OFS_RESULT, 32'h0, "result rst");
    rd_chk(`SAC_OFS_IRQ_MASK, 32'h0, "mask rst");
    rd_chk(8'h14, 32'h0, "unmapped");
    bus(1'b1, `SAC_OFS_IRQ_MASK, 32'h1);
    rd_chk(`SAC_OFS_IRQ_MASK, 32'h1, "mask");
    // Every source in absolute mode; every divider setting but 4 and 5, which fall on the sensors, reaches a pin
    for (int s = 0; s < 8; s++) conv(2'h0, 3'(s % 6), 3'h0, 3'h0, 3'(s), 1);
    conv(2'h1, 3'h0, 3'h1, 3'h0, 3'h2, 2);
    conv(2'h1, 3'h1, 3'h2, 3'h0, 3'h0, 2);
    conv(2'h2, 3'h0, 3'h1, 3'h0, 3'h1, 2);
    conv(2'h3, 3'h0, 3'h1, 3'h4, 3'h6, 3);
    conv(2'h3, 3'h3, 3'h5, 3'h5, 3'h3, 3);
    // Continuous runs on its own until the repeat bit is cleared
    bus(1'b1, `SAC_OFS_CTRL, 32'h13);
    wait_irq();
    rd_chk(`SAC_OFS_IRQ_STAT, 32'h1, "done cont");
    rd_chk(`SAC_OFS_RESULT, 32'h2BC, "result cont");
    rd_chk(`SAC_OFS_STATUS, 32'h1, "restart");
    wait_irq();
    rd_chk(`SAC_OFS_IRQ_STAT, 32'h1, "done again");
    bus(1'b1, `SAC_OFS_CTRL, 32'h10);
    wait_irq();
    rd_chk(`SAC_OFS_IRQ_STAT, 32'h1, "done last");
    repeat (700) @(posedge mclk_i);
    rd_chk(`SAC_OFS_STATUS, 32'h0, "stopped");
    // Masked completion: flag set, line stays low
    bus(1'b1, `SAC_OFS_IRQ_MASK, 32'h0);
    bus(1'b1, `SAC_OFS_CTRL, 32'h1);
    // Enable low mid-trial must hold the trial code and the sample clock
    repeat (400) @(posedge mclk_i);
    ce <= 1'b0;
    @(posedge mclk_i);
    rdv = {21'h0, sclk_o, dac_o};
    repeat (100) @(posedge mclk_i);
    chk32("frozen", rdv, {21'h0, sclk_o, dac_o});
    ce <= 1'b1;
    k = 0;
    do begin
      bus(1'b0, `SAC_OFS_STATUS, 32'h0);
      k++;
    end while (rdv[0] !== 1'b0 && k < 1000);
    chk1("poll", 1'b1, k < 1000);
    chk1("irq masked", 1'b0, irq_o);
    rd_chk(`SAC_OFS_IRQ_STAT, 32'h1, "done masked");
    rd_chk(`SAC_OFS_RESULT, 32'h12C, "result masked");
    chk1("okay", 1'b0, hresp_o);
    complete_run();
  end
endmodule
